// ===== logic/rxom_bus_map.v
// receive output pin assignment for the four decoder/width modes
// assumes a combinational caller that registers the results
`timescale 1ns/1ps
`include "rxom_consts.vh"

module rxom_bus_map (
	input  wire                     enc_bypass_n_in,
	input  wire                     byte8_in,
	input  wire                     is_cmd_in,
	input  wire [`RXOM_WORD_W-1:0]  word_in,
	output reg  [`RXOM_BUS_W-1:0]   bus_out,
	output reg  [`RXOM_CMDL_W-1:0]  cmdl_out
);

	always @* begin
		bus_out  = `RXOM_BUS_RST;
		cmdl_out = `RXOM_CMDL_RST;
		if (!enc_bypass_n_in) begin
			// pre-encoded: raw bits, first bit received on bit 0
			bus_out = word_in[9:0]; // [R10]
			if (!byte8_in) begin
				cmdl_out = {word_in[10], word_in[11]}; // [R11]
			end
		end else if (byte8_in) begin
			if (is_cmd_in) begin
				// 4-bit command: bits 3,2 share data pins 8,9
				bus_out[8] = word_in[3]; // [R8]
				bus_out[9] = word_in[2]; // [R8]
				cmdl_out   = word_in[1:0]; // [R8]
			end else begin
				bus_out[7:0] = word_in[7:0]; // [R8]
			end
		end else begin
			if (is_cmd_in) begin
				cmdl_out = word_in[1:0]; // [R9]
			end else begin
				bus_out = word_in[9:0]; // [R9]
			end
		end
	end

endmodule

// ===== logic/rxom_char_align.v
// character aligner for the fully bypassed raw path
// assumes the sync detector supplies a bit offset and a found flag
`timescale 1ns/1ps
`include "rxom_consts.vh"

module rxom_char_align (
	input  wire                     clk_sys_in,
	input  wire                     rst_n_in,
	input  wire                     byte8_in,
	input  wire                     framing_en_in,
	input  wire                     sync_found_in,
	input  wire [`RXOM_OFS_W-1:0]   sync_offset_in,
	input  wire                     raw_valid_in,
	input  wire [`RXOM_WORD_W-1:0]  raw_bits_in,
	output reg  [`RXOM_WORD_W-1:0]  aligned_out
);

	reg  [`RXOM_WORD_W-1:0]   prev_r;
	reg  [`RXOM_WORD_W-1:0]   prev_nxt;
	reg  [`RXOM_OFS_W-1:0]    ofs;
	reg  [2*`RXOM_WORD_W-1:0] win;

	always @* begin
		prev_nxt = raw_valid_in ? raw_bits_in : prev_r;
		// no shift until framed: output may sit off character boundaries
		ofs = (framing_en_in && sync_found_in) ? sync_offset_in : {`RXOM_OFS_W{1'b0}}; // [R6]
		if (!(framing_en_in && sync_found_in)) begin
			// unframed: the character passes as received, possibly off its boundary
			win = {2*`RXOM_WORD_W{1'b0}};
			aligned_out = byte8_in ? {2'h0, raw_bits_in[9:0]} : raw_bits_in;
		end else if (byte8_in) begin
			win = {4'h0, raw_bits_in[9:0], prev_r[9:0]} >> ofs;
			aligned_out = {2'h0, win[9:0]};
		end else begin
			win = {raw_bits_in, prev_r} >> ofs;
			aligned_out = win[`RXOM_WORD_W-1:0];
		end
	end

	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			prev_r <= `RXOM_WORD_RST;
		end else begin
			prev_r <= prev_nxt;
		end
	end

endmodule

// ===== logic/rxom_consts.vh
// constants for the receive output register and its bus mapping
// assumes inclusion by every rxom design file
`ifndef RXOM_CONSTS_VH
`define RXOM_CONSTS_VH

// widths
`define RXOM_BUS_W        10
`define RXOM_CMDL_W       2
`define RXOM_WORD_W       12
`define RXOM_OFS_W        4
`define RXOM_SYNC_W       6

// positions in the synchronised pin vector
`define RXOM_PIN_CE_N     0
`define RXOM_PIN_REN_N    1
`define RXOM_PIN_ENCODER_BYPASS_SELECT   2
`define RXOM_PIN_BYTE     3
`define RXOM_PIN_FIFO_BYPASS_SELECT  4
`define RXOM_PIN_FRAMING_ENABLE     5

// synchroniser reset value: not addressed, not reading, all paths enabled, framing off
`define RXOM_SYNC_RST     6'h1F

// select handshake states
`define RXOM_ST_W         2
`define RXOM_ST_IDLE      2'h0
`define RXOM_ST_ADDR      2'h1
`define RXOM_ST_READ      2'h2

// output source encodings
`define RXOM_SRC_FIFO     2'h0
`define RXOM_SRC_DEC      2'h1
`define RXOM_SRC_RAW      2'h2

// reset values
`define RXOM_BUS_RST      10'h000
`define RXOM_CMDL_RST     2'h0
`define RXOM_WORD_RST     12'h000

`endif

// ===== logic/rxom_output_stage.v
// receive output register with select handshake, mode mapping and flag gating
// assumes clk_sys_in is the receive clock; upstream inputs share it, pins do not
//
// Behaviour
// [R1] every output register changes only on the rising receive clock edge
// [R2] fifo flag outputs float while chip enable is sampled high
// [R3] read enable one cycle after chip enable low drives bus and starts read
// [R4] pin assignment follows encoder bypass, byte width and fifo bypass inputs
// [R5] with fifo and decoder bypassed, raw characters pass straight to output
// [R6] framed raw characters are aligned to boundaries once sync is found
// [R7] unframed output may be misaligned; host then frames and decodes itself
// [R8] encoded 8-bit: data on bits 7..0, or 4-bit command on data pins 8,9 and the two command lines
// [R9] encoded 10-bit: data on bits 9..0, or command on two command lines
// [R10] pre-encoded 10-bit: raw bits 0..9, first received on bit 0
// [R11] pre-encoded 12-bit: bits 0..9, then 11 and 10 on command lines
// [R12] receive clock is input with fifo on, character-rate output when bypassed
`timescale 1ns/1ps
`include "rxom_consts.vh"

module rxom_output_stage (
	input  wire                     clk_sys_in,
	input  wire                     rst_n_in,
	input  wire                     chip_enable_n_in,
	input  wire                     receive_read_enable_n_in,
	input  wire                     encoder_bypass_select_in,
	input  wire                     byte_width_select_in,
	input  wire                     fifo_bypass_select_in,
	input  wire                     framing_enable_in,
	input  wire [`RXOM_WORD_W-1:0]  fifo_word_in,
	input  wire                     fifo_is_cmd_in,
	input  wire                     fifo_violation_in,
	input  wire                     fifo_full_in,
	input  wire                     fifo_half_in,
	input  wire                     fifo_empty_in,
	input  wire [`RXOM_WORD_W-1:0]  dec_word_in,
	input  wire                     dec_is_cmd_in,
	input  wire                     dec_violation_in,
	input  wire                     dec_valid_in,
	input  wire [`RXOM_WORD_W-1:0]  raw_bits_in,
	input  wire                     raw_valid_in,
	input  wire                     sync_found_in,
	input  wire [`RXOM_OFS_W-1:0]   sync_offset_in,
	output reg  [`RXOM_BUS_W-1:0]   receive_data_bus_out,
	output reg                      receive_data_bus_oe_out,
	output reg  [`RXOM_CMDL_W-1:0]  receive_command_lines_out,
	output reg                      receive_command_lines_oe_out,
	output reg                      data_command_indicator_out,
	output reg                      code_violation_flag_out,
	output reg                      fifo_full_out,
	output reg                      fifo_half_out,
	output reg                      fifo_empty_out,
	output reg                      fifo_flags_oe_out,
	output reg                      fifo_read_out,
	output reg                      receive_clock_out,
	output reg                      receive_clock_oe_out
);

	// pin synchronisers
	wire [`RXOM_SYNC_W-1:0] pin_raw;
	reg  [`RXOM_SYNC_W-1:0] pin_meta_r;
	reg  [`RXOM_SYNC_W-1:0] pin_r;

	assign pin_raw[`RXOM_PIN_CE_N]    = chip_enable_n_in;
	assign pin_raw[`RXOM_PIN_REN_N]   = receive_read_enable_n_in;
	assign pin_raw[`RXOM_PIN_ENCODER_BYPASS_SELECT]  = encoder_bypass_select_in;
	assign pin_raw[`RXOM_PIN_BYTE]    = byte_width_select_in;
	assign pin_raw[`RXOM_PIN_FIFO_BYPASS_SELECT] = fifo_bypass_select_in;
	assign pin_raw[`RXOM_PIN_FRAMING_ENABLE]    = framing_enable_in;

	// reset level per pin: not addressed, not reading, modes high, framing off
	wire [`RXOM_SYNC_W-1:0] sync_rst = `RXOM_SYNC_RST;

	genvar gi;
	generate
		for (gi = 0; gi < `RXOM_SYNC_W; gi = gi + 1) begin : g_sync
			always @(posedge clk_sys_in) begin
				if (!rst_n_in) begin
					pin_meta_r[gi] <= sync_rst[gi];
					pin_r[gi]      <= sync_rst[gi];
				end else begin
					pin_meta_r[gi] <= pin_raw[gi];
					pin_r[gi]      <= pin_meta_r[gi];
				end
			end
		end
	endgenerate

	wire ce_low     = ~pin_r[`RXOM_PIN_CE_N];
	wire ren_low    = ~pin_r[`RXOM_PIN_REN_N];
	wire enc_on     = pin_r[`RXOM_PIN_ENCODER_BYPASS_SELECT];
	wire byte8      = pin_r[`RXOM_PIN_BYTE];
	wire fifo_on    = pin_r[`RXOM_PIN_FIFO_BYPASS_SELECT];
	wire framing_en = pin_r[`RXOM_PIN_FRAMING_ENABLE];

	// source of the output character from the two bypass selects
	function [1:0] rxom_src;
		input fifo_en;
		input enc_en;
		begin
			if (fifo_en) begin
				rxom_src = `RXOM_SRC_FIFO;
			end else if (enc_en) begin
				rxom_src = `RXOM_SRC_DEC;
			end else begin
				rxom_src = `RXOM_SRC_RAW;
			end
		end
	endfunction

	// select handshake states
	localparam [`RXOM_ST_W-1:0] ST_IDLE = 2'h0;
	localparam [`RXOM_ST_W-1:0] ST_ADDR = 2'h1;
	localparam [`RXOM_ST_W-1:0] ST_READ = 2'h2;

	reg [`RXOM_ST_W-1:0] st_r;
	reg [`RXOM_ST_W-1:0] st_nxt;

	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				// read enable alone is ignored until addressed
				if (ce_low) begin
					st_nxt = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (!ce_low) begin
					st_nxt = ST_IDLE;
				end else if (ren_low) begin
					// read enable in the cycle after addressing
					st_nxt = ST_READ; // [R3]
				end
			end
			ST_READ: begin
				// reads continue back to back while both stay low
				if (!ce_low) begin
					st_nxt = ST_IDLE;
				end else if (!ren_low) begin
					st_nxt = ST_ADDR;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	wire selected = (st_nxt == ST_READ);
	wire [1:0] src = rxom_src(fifo_on, enc_on); // [R4]

	// pick the character and whether a new one arrives
	reg [`RXOM_WORD_W-1:0] word_sel;
	reg                    is_cmd_sel;
	reg                    code_violation_flag_sel;
	reg                    load;
	reg                    rd_nxt;
	wire [`RXOM_WORD_W-1:0] aligned;

	rxom_char_align u_align (
		.clk_sys_in     (clk_sys_in),
		.rst_n_in       (rst_n_in),
		.byte8_in       (byte8),
		.framing_en_in  (framing_en),
		.sync_found_in  (sync_found_in),
		.sync_offset_in (sync_offset_in),
		.raw_valid_in   (raw_valid_in),
		.raw_bits_in    (raw_bits_in),
		.aligned_out    (aligned)
	);

	always @* begin
		word_sel   = fifo_word_in;
		is_cmd_sel = fifo_is_cmd_in;
		code_violation_flag_sel   = fifo_violation_in;
		load       = 1'b0;
		rd_nxt     = 1'b0;
		case (src)
			`RXOM_SRC_FIFO: begin
				// a read cycle only while selected and something is stored
				rd_nxt = selected & ~fifo_empty_in; // [R3]
				load   = rd_nxt;
			end
			`RXOM_SRC_DEC: begin
				word_sel   = dec_word_in;
				is_cmd_sel = dec_is_cmd_in;
				code_violation_flag_sel   = dec_violation_in;
				load       = dec_valid_in;
			end
			`RXOM_SRC_RAW: begin
				// no buffer, no decode: every raw character reaches the output
				word_sel   = aligned; // [R5]
				is_cmd_sel = 1'b0;
				code_violation_flag_sel   = 1'b0;
				load       = raw_valid_in; // [R5]
			end
			default: begin
				load = 1'b0;
			end
		endcase
	end

	wire [`RXOM_BUS_W-1:0]  bus_map;
	wire [`RXOM_CMDL_W-1:0] cmdl_map;

	rxom_bus_map u_map (
		.enc_bypass_n_in (enc_on),
		.byte8_in        (byte8),
		.is_cmd_in       (is_cmd_sel),
		.word_in         (word_sel),
		.bus_out         (bus_map),
		.cmdl_out        (cmdl_map)
	);

	wire pre_encoded = ~enc_on;

	// handshake state
	always @(posedge clk_sys_in) begin // [R1]
		if (!rst_n_in) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// character register: holds until the next character is loaded
	always @(posedge clk_sys_in) begin // [R1]
		if (!rst_n_in) begin
			receive_data_bus_out       <= `RXOM_BUS_RST;
			receive_command_lines_out  <= `RXOM_CMDL_RST;
			data_command_indicator_out <= 1'b0;
			code_violation_flag_out    <= 1'b0;
		end else if (load) begin
			receive_data_bus_out      <= bus_map; // [R4]
			receive_command_lines_out <= cmdl_map; // [R4]
			// pre-encoded modes carry no indicator or violation
			data_command_indicator_out <= is_cmd_sel & ~pre_encoded;
			code_violation_flag_out    <= code_violation_flag_sel & ~pre_encoded;
		end
	end

	// bus drivers follow the select handshake, not the character loads
	always @(posedge clk_sys_in) begin // [R1]
		if (!rst_n_in) begin
			receive_data_bus_oe_out      <= 1'b0;
			receive_command_lines_oe_out <= 1'b0;
		end else begin
			receive_data_bus_oe_out      <= selected; // [R3]
			receive_command_lines_oe_out <= selected; // [R3]
		end
	end

	// one read strobe per character taken from the fifo
	always @(posedge clk_sys_in) begin // [R1]
		if (!rst_n_in) begin
			fifo_read_out <= 1'b0;
		end else begin
			fifo_read_out <= rd_nxt; // [R3]
		end
	end

	// status flags: registered copies, driven only while addressed
	always @(posedge clk_sys_in) begin // [R1]
		if (!rst_n_in) begin
			fifo_full_out     <= 1'b0;
			fifo_half_out     <= 1'b0;
			fifo_empty_out    <= 1'b1;
			fifo_flags_oe_out <= 1'b0;
		end else begin
			fifo_full_out     <= fifo_full_in;
			fifo_half_out     <= fifo_half_in;
			fifo_empty_out    <= fifo_empty_in;
			fifo_flags_oe_out <= ce_low; // [R2]
		end
	end

	// character-rate strobe driven out only with the fifo bypassed
	always @(posedge clk_sys_in) begin // [R1]
		if (!rst_n_in) begin
			receive_clock_out    <= 1'b0;
			receive_clock_oe_out <= 1'b0;
		end else begin
			receive_clock_oe_out <= ~fifo_on; // [R12]
			receive_clock_out    <= ~fifo_on & load; // [R12]
		end
	end

endmodule

// ===== verif/rxom_host_model.sv
// host side of the receive port: addresses the device, then reads
// assumes the bench supplies the receive clock
`timescale 1ns/1ps
module rxom_host_model (
	input  wire clk_sys_in,
	output reg  chip_enable_n_out,
	output reg  receive_read_enable_n_out
);
	initial begin
		chip_enable_n_out = 1'b1;
		receive_read_enable_n_out = 1'b1;
	end
	task automatic read_burst(input integer n);
		@(posedge clk_sys_in);
		chip_enable_n_out <= 1'b0;
		@(posedge clk_sys_in);
		receive_read_enable_n_out <= 1'b0;
		repeat (n) @(posedge clk_sys_in);
		receive_read_enable_n_out <= 1'b1;
		chip_enable_n_out <= 1'b1;
	endtask
	// read enable without a prior select
	task automatic stray_read(input integer n);
		@(posedge clk_sys_in);
		receive_read_enable_n_out <= 1'b0;
		repeat (n) @(posedge clk_sys_in);
		receive_read_enable_n_out <= 1'b1;
	endtask
endmodule

// ===== verif/rxom_output_stage_sva.sv
// port checks for the receive output stage
// assumes pin inputs pass a two-flop synchroniser
`timescale 1ns/1ps
module rxom_output_stage_chk (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire chip_enable_n_in,
	input wire receive_read_enable_n_in,
	input wire encoder_bypass_select_in,
	input wire fifo_bypass_select_in,
	input wire fifo_empty_in,
	input wire raw_valid_in,
	input wire receive_data_bus_oe_out,
	input wire receive_command_lines_oe_out,
	input wire data_command_indicator_out,
	input wire code_violation_flag_out,
	input wire fifo_flags_oe_out,
	input wire fifo_read_out,
	input wire receive_clock_out,
	input wire receive_clock_oe_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_raw_mode;
		(!fifo_bypass_select_in && !encoder_bypass_select_in) [*3];
	endsequence
	sequence s_preenc_load;
		(!encoder_bypass_select_in) [*4] ##0 receive_clock_out;
	endsequence
	chk_flags_float: assert property (
		chip_enable_n_in [*3] |=> !fifo_flags_oe_out) else $error("flags driven unselected");
	chk_oe_cause: assert property (
		$rose(receive_data_bus_oe_out) |->
		!$past(receive_read_enable_n_in, 3) && !$past(chip_enable_n_in, 4))
		else $error("bus driven without select");
	chk_oe_release: assert property (
		receive_read_enable_n_in |=> ##2 !receive_data_bus_oe_out) else $error("bus oe stuck");
	chk_read_pulse: assert property (
		fifo_read_out |-> receive_data_bus_oe_out && !$past(fifo_empty_in))
		else $error("bad fifo read");
	chk_cmd_oe_pair: assert property (
		receive_command_lines_oe_out == receive_data_bus_oe_out) else $error("oe mismatch");
	chk_preenc_flags: assert property (
		s_preenc_load |-> !data_command_indicator_out && !code_violation_flag_out)
		else $error("flags set in raw mode");
	chk_clk_input: assert property (
		fifo_bypass_select_in [*4] |-> !receive_clock_oe_out && !receive_clock_out)
		else $error("clock pin driven");
	chk_clk_output: assert property (
		(!fifo_bypass_select_in) [*4] |-> receive_clock_oe_out) else $error("clock pin idle");
	chk_raw_load: assert property (
		s_raw_mode ##0 raw_valid_in |=> receive_clock_out) else $error("raw char not loaded");
endmodule
bind rxom_output_stage rxom_output_stage_chk i_chk (.*);

// ===== verif/tb_top.sv
// self-checking bench for the receive output stage
// assumes the host model drives both select pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic        clk_sys_in = 0, rst_n_in = 0;
	logic        enc = 1, bw = 1, fbyp = 1, frm = 0, sfnd = 0, rval = 0, dval = 0;
	logic        fvio = 0, ffull = 0, fempty = 1, dcmd = 0, dvio = 0;
	logic [3:0]  sofs = 4'h0;
	logic [11:0] fword = 12'h000, dword = 12'h000;
	logic [19:0] cat;
	wire         ce_n, ren_n, oe, ind, vio, ofull, oempty, foe, rd, rclk, rcoe;
	wire [9:0]   bus;
	wire [1:0]   cmd;
	integer      num_errors = 0, n_compared = 0, n_reads = 0;
	rxom_host_model i_host (.clk_sys_in(clk_sys_in), .chip_enable_n_out(ce_n),
		.receive_read_enable_n_out(ren_n));
	rxom_output_stage i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.chip_enable_n_in(ce_n), .receive_read_enable_n_in(ren_n),
		.encoder_bypass_select_in(enc), .byte_width_select_in(bw),
		.fifo_bypass_select_in(fbyp), .framing_enable_in(frm), .fifo_word_in(fword),
		.fifo_is_cmd_in(1'b0), .fifo_violation_in(fvio), .fifo_full_in(ffull),
		.fifo_half_in(1'b0), .fifo_empty_in(fempty), .dec_word_in(dword),
		.dec_is_cmd_in(dcmd), .dec_violation_in(dvio), .dec_valid_in(dval),
		.raw_bits_in(dword), .raw_valid_in(rval), .sync_found_in(sfnd),
		.sync_offset_in(sofs), .receive_data_bus_out(bus), .receive_data_bus_oe_out(oe),
		.receive_command_lines_out(cmd), .receive_command_lines_oe_out(),
		.data_command_indicator_out(ind), .code_violation_flag_out(vio),
		.fifo_full_out(ofull), .fifo_half_out(), .fifo_empty_out(oempty),
		.fifo_flags_oe_out(foe), .fifo_read_out(rd), .receive_clock_out(rclk),
		.receive_clock_oe_out(rcoe));
	always #2 clk_sys_in = ~clk_sys_in;
	always @(negedge clk_sys_in) if (rd === 1'b1) n_reads++;
	task give_verdict;
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one character with the fifo bypassed, through the decoder or the raw path
	task automatic load(input logic e, b, input logic [11:0] w, input logic c,
		input logic [9:0] xb, input logic [1:0] xc);
		@(posedge clk_sys_in);
		enc <= e;
		bw <= b;
		fbyp <= 1'b0;
		dword <= w;
		dcmd <= c;
		dvio <= c;
		repeat (4) @(posedge clk_sys_in);
		dval <= e;
		rval <= !e;
		@(posedge clk_sys_in);
		dval <= 1'b0;
		rval <= 1'b0;
		#1;
		`CHK("char strobe", 1'b1, rclk)
		`CHK("clock oe", 1'b1, rcoe)
		`CHK("data bus", xb, bus)
		`CHK("cmd lines", xc, cmd)
		`CHK("indicator", c & e, ind)
		`CHK("violation", c & e, vio)
	endtask
	initial begin
		repeat (2000) @(posedge clk_sys_in);
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		fword <= 12'h0A5;
		fvio <= 1'b1;
		ffull <= 1'b1;
		fempty <= 1'b0;
		#1;
		`CHK("empty flag", 1'b1, oempty)
		i_host.read_burst(3);
		#1;
		`CHK("flags oe", 1'b1, foe)
		repeat (6) @(posedge clk_sys_in);
		#1;
		`CHK("reads", 3, n_reads)
		`CHK("fifo data", 10'h0A5, bus)
		`CHK("fifo vio", 1'b1, vio)
		`CHK("full flag", 1'b1, ofull)
		`CHK("flags off", 1'b0, foe)
		`CHK("clock oe fifo", 1'b0, rcoe)
		i_host.stray_read(4);
		fempty <= 1'b1;
		i_host.read_burst(2);
		repeat (6) @(posedge clk_sys_in);
		#1;
		`CHK("no reads", 3, n_reads)
		`CHK("bus oe off", 1'b0, oe)
		load(1, 1, 12'h05A, 0, 10'h05A, 2'h0);
		load(1, 1, 12'h00D, 1, 10'h300, 2'h1);
		load(1, 0, 12'h3A5, 0, 10'h3A5, 2'h0);
		load(1, 0, 12'h002, 1, 10'h000, 2'h2);
		load(0, 1, 12'h2C3, 0, 10'h2C3, 2'h0);
		load(0, 0, 12'hA5C, 0, 10'h25C, 2'h1);
		@(posedge clk_sys_in);
		frm <= 1'b1;
		sfnd <= 1'b1;
		sofs <= 4'h3;
		cat = {10'h155, 10'h25C} >> 3;
		load(0, 1, 12'h155, 0, cat[9:0], 2'h0);
		cat = {10'h0F0, 10'h155} >> 3;
		load(0, 1, 12'h0F0, 0, cat[9:0], 2'h0);
		give_verdict;
	end
endmodule
